// *** dv/scs_clock_switch_checker.sv ***
// Assertions on the clock source switch ports
`timescale 1ns/1ps

module scs_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  // Oscillator and power events
  input wire logic        slow_rc_oscillator,
  input wire logic        sleep_request,
  input wire logic        wake_event,
  // Outputs
  input wire logic        watchdog_clk_out,
  input wire logic        sleep_active,
  input wire logic        idle_active
);
  logic [7:0] rd_addr;

  // Remembers which register the pending read data belongs to
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr <= s_axi_araddr;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wdog_follow_a:
    assert property ($past(aresetn) |-> watchdog_clk_out == $past(slow_rc_oscillator))
      else $error("watchdog clock not following slow oscillator");
  mode_excl_a:
    assert property (!(sleep_active && idle_active))
      else $error("sleep and idle both active");
  wake_clear_a:
    assert property (wake_event |=> !sleep_active && !idle_active)
      else $error("wake did not leave low power mode");
  mode_cause_a:
    assert property ($rose(sleep_active) || $rose(idle_active)
                     |-> $past(sleep_request) && !$past(wake_event))
      else $error("low power mode entered without request");
  rsv_code_a:
    assert property (s_axi_rvalid && (rd_addr == 8'h00 || rd_addr == 8'h10)
                     |-> s_axi_rdata[1:0] != 2'b10)
      else $error("reserved source code visible");
  wr_resp_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                     |=> ##1 s_axi_bvalid)
      else $error("write response late");
  wr_block_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
  rd_resp_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read data late");
endmodule // scs_checker

bind scs_clock_switch scs_checker i_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rdata, .slow_rc_oscillator, .sleep_request, .wake_event, .watchdog_clk_out,
  .sleep_active, .idle_active
);

// *** dv/tb_system_clock_source_switch.sv ***
// Self-checking bench for the clock source switch
`timescale 1ns/1ps
`include "scs_consts.svh"

module tb_system_clock_source_switch;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b1;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b1;
  logic        pri_osc = 1'b0;
  logic        sec_osc = 1'b0;
  logic        fast_osc = 1'b0;
  logic        slow_osc = 1'b0;
  logic        sleep_request = 1'b0;
  logic        wake_event = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        device_clk_out, watchdog_clk_out, secondary_osc_run, sleep_active, idle_active;
  int          n_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;

  always #25 aclk = ~aclk;

  // Oscillators at distinct rates so a wrong source shows as a wrong edge count
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    fast_osc <= ~fast_osc;
    if (cyc % 2 == 1) pri_osc <= ~pri_osc;
    if (cyc % 3 == 2) slow_osc <= ~slow_osc;
    if (cyc % 5 == 4) sec_osc <= ~sec_osc;
  end

  scs_clock_switch #(.STARTUP_EDGES(4)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .primary_clk_in(pri_osc), .secondary_clk_in(sec_osc),
    .fast_internal_oscillator(fast_osc), .slow_rc_oscillator(slow_osc),
    .sleep_request(sleep_request), .wake_event(wake_event), .device_clk_out(device_clk_out),
    .watchdog_clk_out(watchdog_clk_out), .secondary_osc_run(secondary_osc_run),
    .sleep_active(sleep_active), .idle_active(idle_active)
  );

  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Ready is looked at on the falling edge, so the rising edge that follows takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, r;
    logic [1:0] rsp;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(negedge aclk);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      @(posedge aclk);
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    do begin
      @(negedge aclk);
      r = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
    end while (!r);
    chk(32'(rsp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    logic r;
    logic [1:0] rsp;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      r = s_axi_arready;
      @(posedge aclk);
    end while (!r);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      r = s_axi_rvalid;
      d = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
    end while (!r);
    chk(32'(rsp), 32'(er));
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v, `SCS_RESP_OKAY);
    chk(v, e);
  endtask

  task automatic poll(input logic [1:0] src);
    logic [31:0] v;
    do rd(8'h10, v, `SCS_RESP_OKAY); while (v[2:0] !== {1'b0, src});
  endtask

  // Counts device clock rises over a window; one edge of slack for phase
  task automatic rises(input int exp, input int len = 1024);
    int n;
    logic p;
    n = 0;
    p = 1'b1;
    repeat (len) begin
      @(negedge aclk);
      n += int'(device_clk_out && !p);
      p = device_clk_out;
    end
    @(posedge aclk);
    chk(32'(n >= exp - 1 && n <= exp + 1), 32'h1);
  endtask

  task automatic nap(input logic ei, input logic es);
    sleep_request <= 1'b1;
    @(posedge aclk);
    sleep_request <= 1'b0;
    @(negedge aclk);
    chk({30'h0, idle_active, sleep_active}, {30'h0, ei, es});
    @(posedge aclk);
    wake_event <= 1'b1;
    @(posedge aclk);
    wake_event <= 1'b0;
    @(negedge aclk);
    chk({30'h0, idle_active, sleep_active}, 32'h0);
    @(posedge aclk);
  endtask

  task automatic t_start;
    rc(8'h10, 32'h0);
    rc(8'h00, 32'h64);
    rc(8'h0C, 32'h2);
    rc(8'h08, 32'h0);
    repeat (40) @(posedge aclk);
    rc(8'h00, 32'h6C);
    wr(8'h00, 32'h61, `SCS_RESP_OKAY);
    rc(8'h00, 32'h6C);
    wr(8'h00, 32'h62, `SCS_RESP_OKAY);
    rc(8'h00, 32'h6C);
  endtask

  task automatic t_switch;
    logic [31:0] v;
    wr(8'h08, 32'h08, `SCS_RESP_OKAY);
    @(negedge aclk);
    chk(32'(secondary_osc_run), 32'h1);
    @(posedge aclk);
    wr(8'h00, 32'h61, `SCS_RESP_OKAY);
    rd(8'h10, v, `SCS_RESP_OKAY);
    chk(v & 32'h7, 32'h4);
    rises(0, 16);
    poll(2'b01);
    rc(8'h08, 32'h48);
    rc(8'h00, 32'h65);
    wr(8'h00, 32'h73, `SCS_RESP_OKAY);
    poll(2'b11);
    rc(8'h08, 32'h08);
    rc(8'h00, 32'h77);
    for (int c = 7; c > 0; c--) begin
      wr(8'h00, 32'h03 | (c << 4), `SCS_RESP_OKAY);
      rises(1024 >> (8 - c));
    end
    wr(8'h00, 32'h03, `SCS_RESP_OKAY);
    rises(170);
    wr(8'h04, 32'h80, `SCS_RESP_OKAY);
    rises(2);
    // Primary taken from the internal block
    wr(8'h0C, 32'h0, `SCS_RESP_OKAY);
    wr(8'h00, 32'h70, `SCS_RESP_OKAY);
    poll(2'b00);
    rises(512);
    wr(8'h00, 32'h73, `SCS_RESP_OKAY);
    poll(2'b11);
  endtask

  task automatic t_power;
    logic [31:0] v;
    nap(1'b0, 1'b0);
    wr(8'h0C, 32'h1002, `SCS_RESP_OKAY);
    wr(8'h00, 32'h83, `SCS_RESP_OKAY);
    nap(1'b1, 1'b0);
    wr(8'h00, 32'h03, `SCS_RESP_OKAY);
    nap(1'b0, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wr(8'h04, (i == 2) ? 32'h80 : 32'hC0, `SCS_RESP_OKAY);
      wr(8'h0C, (i == 0) ? 32'h1022 : 32'h1032, `SCS_RESP_OKAY);
      rd(8'h10, v, `SCS_RESP_OKAY);
      chk(32'(v[6]), 32'(i != 2));
      chk(32'(v[5]), 32'(i != 1));
    end
    wr(8'h14, 32'hFF, `SCS_RESP_SLVERR);
    rd(8'h14, v, `SCS_RESP_SLVERR);
    chk(v, 32'h0);
    // Second reset in mid-run while the internal clock is selected
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(8'h10, 32'h0);
    rc(8'h00, 32'h64);
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_start();
    t_switch();
    t_power();
    end_sim();
  end

  // About four times the expected run length
  initial begin
    #2_000_000;
    n_errors++;
    end_sim();
  end
endmodule // tb_system_clock_source_switch

// *** pkg/scs_consts.svh ***
// Constants for the system clock source switch
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH
// Register byte addresses
`define SCS_ADDR_OSC_CTRL   8'h00
`define SCS_ADDR_OSC_TUNE   8'h04
`define SCS_ADDR_SEC_CTRL   8'h08
`define SCS_ADDR_CFG        8'h0C
`define SCS_ADDR_STATUS     8'h10
// osc_ctrl fields
`define SCS_IDLE_BIT        7
`define SCS_IFS_HI          6
`define SCS_IFS_LO          4
`define SCS_PRIMARY_STARTUP_DONE_BIT        3
`define SCS_ONE_BIT         2
`define SCS_CSS_HI          1
`define SCS_CSS_LO          0
// osc_tune fields
`define SCS_LFS_BIT         7
`define SCS_PLL_BIT         6
`define SCS_TUNE_HI         5
// secondary_timer_control fields
`define SCS_SEC_ACT_BIT     6
`define SCS_SEC_EN_BIT      3
// cfg fields
`define SCS_PMC_HI          2
`define SCS_CPDIV_LO        4
`define SCS_CPDIV_HI        5
`define SCS_PLLDIV_LO       8
`define SCS_PLLDIV_HI       10
`define SCS_PM_EN_BIT       12
// status fields
`define SCS_ST_ACT_HI       1
`define SCS_ST_ACT_LO       0
`define SCS_ST_SWITCH_BIT   2
`define SCS_ST_SLEEP_BIT    3
`define SCS_ST_IDLE_BIT     4
`define SCS_ST_USB_LS_BIT   5
`define SCS_ST_USB_FS_BIT   6
`define SCS_ST_OST_BIT      7
// Source codes
`define SCS_SRC_PRI         2'b00
`define SCS_SRC_SEC         2'b01
`define SCS_SRC_RSV         2'b10
`define SCS_SRC_INT         2'b11
// Frequency codes
`define SCS_IFS_8M          3'b111
`define SCS_IFS_4M          3'b110
`define SCS_IFS_31K         3'b000
`define SCS_IFS_RESET       3'b110
// Primary mode codes; the two INT codes run from the internal block, the reset code does not
`define SCS_PMC_INT0        3'b000
`define SCS_PMC_INT1        3'b001
`define SCS_PMC_RESET       3'b010
// Cpu divider code giving 24 MHz from 48 MHz
`define SCS_CPDIV_HALF      2'b10
`define SCS_CPDIV_NONE      2'b11
// Switch pause in source edges
`define SCS_OLD_EDGES       3'd2
`define SCS_NEW_EDGES       3'd3
// Startup timer
`define SCS_OST_W           16
// Bus answers
`define SCS_RESP_OKAY       2'b00
`define SCS_RESP_SLVERR     2'b10
`endif

// *** pkg/scs_pkg.sv ***
// Types for the system clock source switch
package scs_pkg;
  `include "scs_consts.svh"

  typedef enum logic [1:0] {
    SCS_RUN   = 2'b00,
    SCS_DRAIN = 2'b01,
    SCS_FILL  = 2'b11
  } scs_fsm_e;

  typedef struct packed {
    scs_fsm_e                fsm;
    logic [1:0]              css;
    logic [1:0]              active;
    logic [1:0]              old_src;
    logic [2:0]              edge_cnt;
    logic [2:0]              ifs;
    logic                    lfs;
    logic                    pll_en;
    logic [5:0]              tune;
    logic                    idle;
    logic                    sec_en;
    logic [2:0]              pmc;
    logic [1:0]              cpdiv;
    logic [2:0]              plldiv;
    logic                    pm_en;
    logic [7:0]              pscnt;
    logic                    prev_pri;
    logic                    prev_sec;
    logic                    prev_fast;
    logic                    prev_int;
    logic [`SCS_OST_W-1:0]   startup_timer;
    logic                    pri_ready;
    logic                    clk_out;
    logic                    wdt_clk;
    logic                    sleeping;
    logic                    idling;
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [1:0]              rresp;
    logic [31:0]             rdata;
    logic                    aw_hold;
    logic                    w_hold;
    logic [7:0]              awaddr;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
  } scs_state_s;
endpackage

// *** verilog/scs_clock_switch.sv ***
// System clock source switch with AXI4-Lite control registers
//
// Notes on behaviour
// - Source field picks primary, secondary or internal.
// - Write to source field switches after pause.
// - Any reset clears source field to primary.
// - Frequency field picks internal postscaler output.
// - Frequency change acts at once when running.
// - Postscaler defaults to 4 MHz at reset.
// - Low-frequency bit picks fast/256 or slow RC.
// - Watchdog always uses slow RC.
// - Startup done needs timer expiry and primary active.
// - Secondary active flag while secondary drives clock.
// - Both source flags never set together.
// - Both flags clear means RC, starting or switching.
// - Idle bit chooses sleep or idle on sleep.
// - Secondary select ignored while oscillator disabled.
// - Primary mode config picks primary clock kind.
// - Secondary oscillator keeps running in power-managed modes.
// - Power-managed modes need cfg enable bit pm_en set.
// - Non-24 MHz multiplier clocks mean full speed only.
// - Low speed needs 24 MHz core, 6 MHz USB.
// - Frequency code table, 111 fast down to 000.
// - Source codes: 11 internal, 10 reserved, 01 secondary.
// - Idle bit set gives idle, clear gives sleep.
// - Glitch-free switch: two old, three new edges.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "scs_consts.svh"

module scs_clock_switch
  import scs_pkg::*;
#(
  parameter int STARTUP_EDGES = 1024
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address channel
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // Write data channel
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // Write response channel
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read address channel
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // Read data channel
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Oscillator levels, sampled on aclk
  input  wire logic        primary_clk_in,
  input  wire logic        secondary_clk_in,
  input  wire logic        fast_internal_oscillator,
  input  wire logic        slow_rc_oscillator,
  // Power management events
  input  wire logic        sleep_request,
  input  wire logic        wake_event,
  // Clock outputs and status
  output logic             device_clk_out,
  output logic             watchdog_clk_out,
  output logic             secondary_osc_run,
  output logic             sleep_active,
  output logic             idle_active
);

  scs_state_s r;
  scs_state_s n;

  logic       int_level;
  logic       pri_level;
  logic       pri_rise;
  logic       sec_rise;
  logic       int_rise;
  logic       fast_rise;
  logic       old_rise;
  logic       new_rise;
  logic       sel_level;
  logic       wr_fire;
  logic [7:0] ctrl_rd;
  logic       switching;
  logic       pri_flag;
  logic       sec_flag;
  logic       usb_low_ok;
  logic       usb_full_ok;

  // Postscaler tap per frequency code
  always_comb begin
    unique case (r.ifs)
      `SCS_IFS_8M: int_level = fast_internal_oscillator;
      3'b110:      int_level = r.pscnt[0];
      3'b101:      int_level = r.pscnt[1];
      3'b100:      int_level = r.pscnt[2];
      3'b011:      int_level = r.pscnt[3];
      3'b010:      int_level = r.pscnt[4];
      3'b001:      int_level = r.pscnt[5];
      `SCS_IFS_31K: int_level = r.lfs ? r.pscnt[7] : slow_rc_oscillator;
    endcase
  end

  // Internal-block primary modes run from the postscaler
  assign pri_level = (r.pmc == `SCS_PMC_INT0 || r.pmc == `SCS_PMC_INT1) ?
                     int_level : primary_clk_in;
  assign pri_rise  = pri_level & ~r.prev_pri;
  assign sec_rise  = secondary_clk_in & ~r.prev_sec;
  assign int_rise  = int_level & ~r.prev_int;
  assign fast_rise = fast_internal_oscillator & ~r.prev_fast;

  function automatic logic pick(input logic [1:0] src, input logic p, input logic s,
                                input logic i);
    unique case (src)
      `SCS_SRC_PRI: pick = p;
      `SCS_SRC_SEC: pick = s;
      default:      pick = i;
    endcase
  endfunction

  assign old_rise  = pick(r.old_src, pri_rise, sec_rise, int_rise);
  assign new_rise  = pick(r.css, pri_rise, sec_rise, int_rise);
  assign sel_level = pick(r.active, pri_level, secondary_clk_in, int_level);

  // Core at 24 MHz from multiplier or 24 MHz input
  assign usb_low_ok  = r.pll_en ? (r.cpdiv == `SCS_CPDIV_HALF) :
                       (r.cpdiv == `SCS_CPDIV_NONE);
  assign usb_full_ok = r.pll_en;

  // Flags name a source only once the sequencer has finished moving to it
  assign switching = (r.fsm != SCS_RUN);
  assign pri_flag  = r.pri_ready && (r.active == `SCS_SRC_PRI) &&
                     !switching;
  assign sec_flag  = (r.active == `SCS_SRC_SEC) && !switching;
  assign ctrl_rd   = {r.idle, r.ifs, pri_flag, 1'b1, r.css};

  assign wr_fire = r.aw_hold && r.w_hold && !r.bvalid;

  always_comb begin
    n = r;
    n.prev_pri  = pri_level;
    n.prev_sec  = secondary_clk_in;
    n.prev_fast = fast_internal_oscillator;
    n.prev_int  = int_level;
    n.wdt_clk   = slow_rc_oscillator;
    if (fast_rise) begin
      n.pscnt = r.pscnt + 8'h01;
    end

    // Startup timer counts primary edges once after reset
    if (!r.pri_ready && pri_rise) begin
      if (r.startup_timer == `SCS_OST_W'(STARTUP_EDGES - 1)) begin
        n.pri_ready = 1'b1;
      end else begin
        n.startup_timer = r.startup_timer + `SCS_OST_W'(1);
      end
    end

    // Glitch-free switch sequencer
    unique case (r.fsm)
      SCS_RUN: begin
        n.clk_out = sel_level;
        if (r.css != r.active) begin
          n.fsm      = SCS_DRAIN;
          n.old_src  = r.active;
          n.edge_cnt = 3'd0;
        end
      end
      SCS_DRAIN: begin
        n.clk_out = 1'b0;
        if (old_rise) begin
          n.edge_cnt = r.edge_cnt + 3'd1;
          if (r.edge_cnt + 3'd1 == `SCS_OLD_EDGES) begin
            n.fsm      = SCS_FILL;
            n.edge_cnt = 3'd0;
          end
        end
      end
      SCS_FILL: begin
        n.clk_out = 1'b0;
        // A stopped new source stalls here until it starts
        if (new_rise) begin
          n.edge_cnt = r.edge_cnt + 3'd1;
          if (r.edge_cnt + 3'd1 == `SCS_NEW_EDGES) begin
            n.fsm    = SCS_RUN;
            n.active = r.css;
          end
        end
      end
      default: begin
        // Illegal code: hold the clock low and resume on the active source
        n.fsm     = SCS_RUN;
        n.clk_out = 1'b0;
      end
    endcase

    // Sleep and idle entry, left on wake
    if (wake_event) begin
      n.sleeping = 1'b0;
      n.idling   = 1'b0;
    end else if (sleep_request && r.pm_en && !r.sleeping && !r.idling) begin
      n.idling   = r.idle;
      n.sleeping = !r.idle;
    end

    // Write channel
    if (s_axi_awvalid && r.awready) begin
      n.aw_hold = 1'b1;
      n.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      n.w_hold = 1'b1;
      n.wdata  = s_axi_wdata;
      n.wstrb  = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_fire) begin
      n.aw_hold = 1'b0;
      n.w_hold  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = `SCS_RESP_OKAY;
      unique case (r.awaddr)
        `SCS_ADDR_OSC_CTRL: begin
          if (r.wstrb[0]) begin
            n.idle = r.wdata[`SCS_IDLE_BIT];
            n.ifs  = r.wdata[`SCS_IFS_HI:`SCS_IFS_LO];
            // Reserved code and unready secondary leave the field alone
            if (r.wdata[`SCS_CSS_HI:`SCS_CSS_LO] != `SCS_SRC_RSV &&
                !(r.wdata[`SCS_CSS_HI:`SCS_CSS_LO] == `SCS_SRC_SEC && !r.sec_en)) begin
              n.css = r.wdata[`SCS_CSS_HI:`SCS_CSS_LO];
            end
          end
        end
        `SCS_ADDR_OSC_TUNE: begin
          if (r.wstrb[0]) begin
            n.lfs    = r.wdata[`SCS_LFS_BIT];
            n.pll_en = r.wdata[`SCS_PLL_BIT];
            n.tune   = r.wdata[`SCS_TUNE_HI:0];
          end
        end
        `SCS_ADDR_SEC_CTRL: begin
          if (r.wstrb[0]) begin
            n.sec_en = r.wdata[`SCS_SEC_EN_BIT];
          end
        end
        `SCS_ADDR_CFG: begin
          if (r.wstrb[0]) begin
            n.pmc   = r.wdata[`SCS_PMC_HI:0];
            n.cpdiv = r.wdata[`SCS_CPDIV_HI:`SCS_CPDIV_LO];
          end
          if (r.wstrb[1]) begin
            n.plldiv = r.wdata[`SCS_PLLDIV_HI:`SCS_PLLDIV_LO];
            n.pm_en  = r.wdata[`SCS_PM_EN_BIT];
          end
        end
        default: n.bresp = `SCS_RESP_SLVERR;
      endcase
    end
    n.awready = !n.aw_hold && !n.bvalid;
    n.wready  = !n.w_hold && !n.bvalid;

    // Read channel
    if (s_axi_rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = `SCS_RESP_OKAY;
      n.rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        `SCS_ADDR_OSC_CTRL: n.rdata[7:0] = ctrl_rd;
        `SCS_ADDR_OSC_TUNE: n.rdata[7:0] = {r.lfs, r.pll_en, r.tune};
        `SCS_ADDR_SEC_CTRL: begin
          n.rdata[`SCS_SEC_ACT_BIT] = sec_flag;
          n.rdata[`SCS_SEC_EN_BIT]  = r.sec_en;
        end
        `SCS_ADDR_CFG: begin
          n.rdata[`SCS_PMC_HI:0]                   = r.pmc;
          n.rdata[`SCS_CPDIV_HI:`SCS_CPDIV_LO]     = r.cpdiv;
          n.rdata[`SCS_PLLDIV_HI:`SCS_PLLDIV_LO]   = r.plldiv;
          n.rdata[`SCS_PM_EN_BIT]                  = r.pm_en;
        end
        `SCS_ADDR_STATUS: begin
          n.rdata[`SCS_ST_ACT_HI:`SCS_ST_ACT_LO] = r.active;
          n.rdata[`SCS_ST_SWITCH_BIT]            = switching;
          n.rdata[`SCS_ST_SLEEP_BIT]             = r.sleeping;
          n.rdata[`SCS_ST_IDLE_BIT]              = r.idling;
          n.rdata[`SCS_ST_USB_LS_BIT]            = usb_low_ok;
          n.rdata[`SCS_ST_USB_FS_BIT]            = usb_full_ok;
          n.rdata[`SCS_ST_OST_BIT]               = r.pri_ready;
        end
        default: n.rresp = `SCS_RESP_SLVERR;
      endcase
    end
    n.arready = !n.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r           <= '0;
      r.fsm       <= SCS_RUN;
      r.css       <= `SCS_SRC_PRI;
      r.active    <= `SCS_SRC_PRI;
      r.ifs       <= `SCS_IFS_RESET;
      r.pmc       <= `SCS_PMC_RESET;
      r.awready   <= 1'b1;
      r.wready    <= 1'b1;
      r.arready   <= 1'b1;
      // Preload the samples so no false edge is counted after reset
      r.prev_pri  <= pri_level;
      r.prev_sec  <= secondary_clk_in;
      r.prev_fast <= fast_internal_oscillator;
      r.prev_int  <= int_level;
    end else begin
      r <= n;
    end
  end

  assign s_axi_awready     = r.awready;
  assign s_axi_wready      = r.wready;
  assign s_axi_bvalid      = r.bvalid;
  assign s_axi_bresp       = r.bresp;
  assign s_axi_arready     = r.arready;
  assign s_axi_rvalid      = r.rvalid;
  assign s_axi_rresp       = r.rresp;
  assign s_axi_rdata       = r.rdata;
  assign device_clk_out    = r.clk_out;
  assign watchdog_clk_out  = r.wdt_clk;
  assign secondary_osc_run = r.sec_en;
  assign sleep_active      = r.sleeping;
  assign idle_active       = r.idling;

endmodule // scs_clock_switch
